// *** srik_pkg.sv ***
// constants and types shared by the socket rx / irq / keep-alive register group
package srik_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets (pointer pairs: msb at the lower address)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SRIK_OFS_RXRD_HI = 8'h28;
  localparam logic [7:0] SRIK_OFS_RXRD_LO = 8'h29;
  localparam logic [7:0] SRIK_OFS_RXWR_HI = 8'h2a;
  localparam logic [7:0] SRIK_OFS_RXWR_LO = 8'h2b;
  localparam logic [7:0] SRIK_OFS_MASK = 8'h2c;
  localparam logic [7:0] SRIK_OFS_FRAG_HI = 8'h2d;
  localparam logic [7:0] SRIK_OFS_FRAG_LO = 8'h2e;
  localparam logic [7:0] SRIK_OFS_KAIVL = 8'h2f;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SRIK_RST_RXPTR = 16'h0000;
  localparam logic [7:0] SRIK_RST_MASK = 8'hff;
  localparam logic [15:0] SRIK_RST_FRAG = 16'h4000;
  localparam logic [7:0] SRIK_RST_KAIVL = 8'h00;
  localparam logic [7:0] SRIK_RST_RDATA = 8'h00;

  // ---------------------------------------------------------------------------
  // socket event bit positions
  // ---------------------------------------------------------------------------
  localparam int SRIK_EVT_W = 5;
  localparam int SRIK_EVT_TX_DONE = 4;
  localparam int SRIK_EVT_TIMEOUT = 3;
  localparam int SRIK_EVT_RECEIVE = 2;
  localparam int SRIK_EVT_PEER_CLOSED = 1;
  localparam int SRIK_EVT_LINK_UP = 0;
  localparam logic [4:0] SRIK_RST_FLAGS = 5'h00;

  // ---------------------------------------------------------------------------
  // keep-alive timing
  // ---------------------------------------------------------------------------
  localparam int SRIK_CLK_HZ = 50000000;
  localparam int SRIK_KA_UNIT_S = 5;
  localparam int SRIK_KA_UNIT_CYC = SRIK_KA_UNIT_S * SRIK_CLK_HZ;
  localparam int SRIK_TICK_W = 28;
  localparam logic [27:0] SRIK_RST_TICK = 28'h0000000;
  localparam logic [7:0] SRIK_RST_UNIT = 8'h00;

  typedef enum logic [1:0] {
    KA_IDLE = 2'b00,
    KA_WAIT_DATA = 2'b01,
    KA_LIVE = 2'b10
  } srik_ka_state_t;

endpackage

// *** srik_ka_timer.sv ***
// keep-alive period timer: one fire pulse per elapsed interval
`timescale 1ns/10ps
module srik_ka_timer
  import srik_pkg::*;
#(
  parameter int KA_UNIT_CYCLES = SRIK_KA_UNIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [7:0] interval,
  output logic fire
);

  localparam logic [27:0] UNIT_LAST = 28'(KA_UNIT_CYCLES - 1);

  logic [27:0] tickCnt_ff, nxt_tickCnt;
  logic [7:0] unitCnt_ff, nxt_unitCnt;
  logic fire_ff, nxt_fire;
  logic [7:0] unitInc;

  assign fire = fire_ff;

  always_comb begin
    nxt_tickCnt = tickCnt_ff;
    nxt_unitCnt = unitCnt_ff;
    nxt_fire = 1'b0;
    unitInc = unitCnt_ff + 8'h01;
    if (!run || interval == 8'h00) begin
      nxt_tickCnt = SRIK_RST_TICK;
      nxt_unitCnt = SRIK_RST_UNIT;
    end else if (tickCnt_ff >= UNIT_LAST) begin
      nxt_tickCnt = SRIK_RST_TICK;
      // a shrunk interval fires at the next unit end rather than waiting for a wrap
      if (unitInc >= interval) begin
        nxt_unitCnt = SRIK_RST_UNIT;
        nxt_fire = 1'b1;
      end else begin
        nxt_unitCnt = unitInc;
      end
    end else begin
      nxt_tickCnt = tickCnt_ff + 28'h0000001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_ff <= SRIK_RST_TICK;
      unitCnt_ff <= SRIK_RST_UNIT;
      fire_ff <= 1'b0;
    end else if (ce) begin
      tickCnt_ff <= nxt_tickCnt;
      unitCnt_ff <= nxt_unitCnt;
      fire_ff <= nxt_fire;
    end
  end

  property p_fire_needs_run;
    @(posedge clk) disable iff (sys_rst)
      $rose(fire) |-> $past(run) && $past(interval) != 8'h00;
  endproperty
  a_fire_needs_run: assert property (p_fire_needs_run)
    else $error("keep-alive fired while stopped or zero interval");

endmodule

// *** srik_evt_flags.sv ***
// socket event flags gated by the mask, and the interrupt request term
`timescale 1ns/10ps
module srik_evt_flags
  import srik_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [4:0] sockEvent,
  input wire logic [4:0] eventMask,
  input wire logic [4:0] flagClear,
  input wire logic globalSockBit,
  output logic [4:0] eventFlags,
  output logic irqActive
);

  logic [4:0] flags_ff, nxt_flags;

  assign eventFlags = flags_ff;
  assign irqActive = (|(flags_ff & eventMask)) & globalSockBit;

  // set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < SRIK_EVT_W; gi++) begin : g_flag
      always_comb begin
        nxt_flags[gi] = (sockEvent[gi] & eventMask[gi]) | (flags_ff[gi] & ~flagClear[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= SRIK_RST_FLAGS;
    end else if (ce) begin
      flags_ff <= nxt_flags;
    end
  end

  property p_masked_no_set;
    @(posedge clk) disable iff (sys_rst)
      ##1 ((flags_ff & ~$past(flags_ff) & ~$past(eventMask)) == 5'h00);
  endproperty
  a_masked_no_set: assert property (p_masked_no_set)
    else $error("flag set although its mask bit was zero");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst)
      ce && (|(sockEvent & eventMask & flagClear)) |=>
        ((flags_ff & $past(sockEvent & eventMask & flagClear)) ==
          $past(sockEvent & eventMask & flagClear));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a simultaneous clear");

endmodule

// *** srik_regs.sv ***
// socket rx pointers, event mask, fragment field and keep-alive control
// Functional notes
// - read pointer resets to zero and is cleared by socket initialisation
// - receive-done command hands the new read position to the device
// - read-only write pointer, cleared on init, advanced by received bytes
// - write pointer wraps modulo 65536, carry dropped
// - pointer registers hold msb at lower address, lsb at next
// - eight-bit mask resets to all ones; bits 4..0 mask events
// - event flag sets only when its mask bit is one
// - irq pin low while flag, mask and global socket bit are one
// - fragment register, reset 0x4000, drives ip header fragment field
// - keep-alive interval in 5 s units, honoured only in tcp mode
// - no probe before connected state and at least one data transfer
// - nonzero interval sends a probe each time the period elapses
// - zero interval disables auto probing; manual command sends one probe
// - manual keep-alive command ignored while the interval is nonzero
`timescale 1ns/10ps
module srik_regs
  import srik_pkg::*;
#(
  parameter int KA_UNIT_CYCLES = SRIK_KA_UNIT_CYC,
  parameter logic [7:0] STATE_CONNECTED = 8'h01
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic sockInitCmd,
  input wire logic receiveDoneCmd,
  input wire logic manualKaCmd,
  input wire logic rxWrAdvance,
  input wire logic [15:0] rxByteCount,
  input wire logic [4:0] sockEvent,
  input wire logic [4:0] eventFlagClear,
  input wire logic globalSockBit,
  input wire logic [7:0] socketState,
  input wire logic tcpMode,
  input wire logic dataXfer,
  output logic [15:0] rxReadPtr,
  output logic [15:0] rxFreedPtr,
  output logic [15:0] rxWritePtr,
  output logic [15:0] ipFragField,
  output logic [7:0] keepaliveInterval,
  output logic probePacket,
  output logic [4:0] socketEventFlags,
  output logic hostIrqPinLow
);

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic wrRdHi, wrRdLo, wrMask, wrFragHi, wrFragLo, wrKa;

  assign wrRdHi = regWrEn & hit(regAddr, SRIK_OFS_RXRD_HI);
  assign wrRdLo = regWrEn & hit(regAddr, SRIK_OFS_RXRD_LO);
  assign wrMask = regWrEn & hit(regAddr, SRIK_OFS_MASK);
  assign wrFragHi = regWrEn & hit(regAddr, SRIK_OFS_FRAG_HI);
  assign wrFragLo = regWrEn & hit(regAddr, SRIK_OFS_FRAG_LO);
  assign wrKa = regWrEn & hit(regAddr, SRIK_OFS_KAIVL);

  // ---------------------------------------------------------------------------
  // rx pointers
  // ---------------------------------------------------------------------------
  logic [15:0] rdPtr_ff, nxt_rdPtr;
  logic [15:0] freedPtr_ff, nxt_freedPtr;
  logic [15:0] wrPtr_ff, nxt_wrPtr;

  always_comb begin
    nxt_rdPtr = rdPtr_ff;
    nxt_freedPtr = freedPtr_ff;
    nxt_wrPtr = wrPtr_ff;
    // host updates the read pointer one byte at a time, msb first address
    if (wrRdHi) begin
      nxt_rdPtr[15:8] = regWrData;
    end
    if (wrRdLo) begin
      nxt_rdPtr[7:0] = regWrData;
    end
    if (receiveDoneCmd) begin
      nxt_freedPtr = rdPtr_ff;
    end
    if (rxWrAdvance) begin
      nxt_wrPtr = 16'(wrPtr_ff + rxByteCount);
    end
    // initialisation overrides any same-cycle write or advance
    if (sockInitCmd) begin
      nxt_rdPtr = SRIK_RST_RXPTR;
      nxt_freedPtr = SRIK_RST_RXPTR;
      nxt_wrPtr = SRIK_RST_RXPTR;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdPtr_ff <= SRIK_RST_RXPTR;
      freedPtr_ff <= SRIK_RST_RXPTR;
      wrPtr_ff <= SRIK_RST_RXPTR;
    end else if (ce) begin
      rdPtr_ff <= nxt_rdPtr;
      freedPtr_ff <= nxt_freedPtr;
      wrPtr_ff <= nxt_wrPtr;
    end
  end

  assign rxReadPtr = rdPtr_ff;
  assign rxFreedPtr = freedPtr_ff;
  assign rxWritePtr = wrPtr_ff;

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0] mask_ff, nxt_mask;
  logic [15:0] frag_ff, nxt_frag;
  logic [7:0] kaIvl_ff, nxt_kaIvl;

  always_comb begin
    nxt_mask = mask_ff;
    nxt_frag = frag_ff;
    nxt_kaIvl = kaIvl_ff;
    if (wrMask) begin
      nxt_mask = regWrData;
    end
    if (wrFragHi) begin
      nxt_frag[15:8] = regWrData;
    end
    if (wrFragLo) begin
      nxt_frag[7:0] = regWrData;
    end
    if (wrKa) begin
      nxt_kaIvl = regWrData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff <= SRIK_RST_MASK;
      frag_ff <= SRIK_RST_FRAG;
      kaIvl_ff <= SRIK_RST_KAIVL;
    end else if (ce) begin
      mask_ff <= nxt_mask;
      frag_ff <= nxt_frag;
      kaIvl_ff <= nxt_kaIvl;
    end
  end

  assign ipFragField = frag_ff;
  assign keepaliveInterval = kaIvl_ff;

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  logic [7:0] rdData_ff, nxt_rdData;

  always_comb begin
    nxt_rdData = rdData_ff;
    if (regRdEn) begin
      case (regAddr)
        SRIK_OFS_RXRD_HI: nxt_rdData = rdPtr_ff[15:8];
        SRIK_OFS_RXRD_LO: nxt_rdData = rdPtr_ff[7:0];
        SRIK_OFS_RXWR_HI: nxt_rdData = wrPtr_ff[15:8];
        SRIK_OFS_RXWR_LO: nxt_rdData = wrPtr_ff[7:0];
        SRIK_OFS_MASK: nxt_rdData = mask_ff;
        SRIK_OFS_FRAG_HI: nxt_rdData = frag_ff[15:8];
        SRIK_OFS_FRAG_LO: nxt_rdData = frag_ff[7:0];
        SRIK_OFS_KAIVL: nxt_rdData = kaIvl_ff;
        default: nxt_rdData = SRIK_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_ff <= SRIK_RST_RDATA;
    end else if (ce) begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

  // ---------------------------------------------------------------------------
  // event flags and interrupt pin
  // ---------------------------------------------------------------------------
  logic irqActive;
  logic irqLow_ff, nxt_irqLow;

  srik_evt_flags u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .sockEvent(sockEvent),
    .eventMask(mask_ff[4:0]),
    .flagClear(eventFlagClear),
    .globalSockBit(globalSockBit),
    .eventFlags(socketEventFlags),
    .irqActive(irqActive)
  );

  always_comb begin
    nxt_irqLow = ~irqActive;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqLow_ff <= 1'b1;
    end else if (ce) begin
      irqLow_ff <= nxt_irqLow;
    end
  end

  assign hostIrqPinLow = irqLow_ff;

  // ---------------------------------------------------------------------------
  // keep-alive control
  // ---------------------------------------------------------------------------
  srik_ka_state_t kaState_ff, nxt_kaState;
  logic probe_ff, nxt_probe;
  logic connected, kaRun, kaFire;

  assign connected = tcpMode && (socketState == STATE_CONNECTED);
  assign kaRun = (kaState_ff == KA_LIVE);

  srik_ka_timer #(
    .KA_UNIT_CYCLES(KA_UNIT_CYCLES)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(kaRun),
    .interval(kaIvl_ff),
    .fire(kaFire)
  );

  always_comb begin
    nxt_kaState = kaState_ff;
    nxt_probe = 1'b0;
    case (kaState_ff)
      KA_IDLE: begin
        if (connected) begin
          nxt_kaState = KA_WAIT_DATA;
        end
      end
      KA_WAIT_DATA: begin
        if (!connected) begin
          nxt_kaState = KA_IDLE;
        end else if (dataXfer) begin
          nxt_kaState = KA_LIVE;
        end
      end
      KA_LIVE: begin
        if (!connected) begin
          nxt_kaState = KA_IDLE;
        end else if (kaIvl_ff != 8'h00) begin
          nxt_probe = kaFire;
        end else begin
          nxt_probe = manualKaCmd;
        end
      end
      default: nxt_kaState = KA_IDLE;
    endcase
    if (sockInitCmd) begin
      nxt_kaState = KA_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kaState_ff <= KA_IDLE;
      probe_ff <= 1'b0;
    end else if (ce) begin
      kaState_ff <= nxt_kaState;
      probe_ff <= nxt_probe;
    end
  end

  assign probePacket = probe_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [7:0] rdPtrHi;

  assign rdPtrHi = rdPtr_ff[15:8];

  property p_init_clears;
    @(posedge clk) disable iff (sys_rst)
      ce && sockInitCmd |=> rdPtr_ff == 16'h0000 && wrPtr_ff == 16'h0000;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("init did not clear rx pointers");

  property p_wr_wrap;
    @(posedge clk) disable iff (sys_rst)
      ce && rxWrAdvance && !sockInitCmd |=>
        wrPtr_ff == 16'($past(wrPtr_ff) + $past(rxByteCount));
  endproperty
  a_wr_wrap: assert property (p_wr_wrap)
    else $error("write pointer advance wrong");

  property p_rd_msb;
    @(posedge clk) disable iff (sys_rst)
      ce && regRdEn && regAddr == SRIK_OFS_RXRD_HI |=> regRdData == $past(rdPtrHi);
  endproperty
  a_rd_msb: assert property (p_rd_msb)
    else $error("read pointer msb not at lower address");

  property p_receive_done_cmd_done;
    @(posedge clk) disable iff (sys_rst)
      ce && receiveDoneCmd && !sockInitCmd |=> freedPtr_ff == $past(rdPtr_ff);
  endproperty
  a_receive_done_cmd_done: assert property (p_receive_done_cmd_done)
    else $error("receive-done did not capture read pointer");

  property p_irq_pin;
    @(posedge clk) disable iff (sys_rst)
      ce |=> irqLow_ff == !$past(irqActive);
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("irq pin does not follow flags and mask");

  sequence s_live_prev;
    $past(kaState_ff) == KA_LIVE;
  endsequence

  property p_probe_live;
    @(posedge clk) disable iff (sys_rst)
      $rose(probe_ff) |-> s_live_prev;
  endproperty
  a_probe_live: assert property (p_probe_live)
    else $error("probe sent before connection and data");

  property p_manual_ignored;
    @(posedge clk) disable iff (sys_rst)
      ce && manualKaCmd && kaIvl_ff != 8'h00 && !kaFire |=> !probe_ff;
  endproperty
  a_manual_ignored: assert property (p_manual_ignored)
    else $error("manual probe honoured with nonzero interval");

  property p_manual_sent;
    @(posedge clk) disable iff (sys_rst)
      ce && manualKaCmd && kaIvl_ff == 8'h00 && kaRun && connected && !sockInitCmd
        |=> probe_ff;
  endproperty
  a_manual_sent: assert property (p_manual_sent)
    else $error("manual probe not sent");

  property p_mask_reset;
    @(posedge clk) $fell(sys_rst) |-> mask_ff == 8'hff && frag_ff == 16'h4000;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask or fragment reset value wrong");

endmodule

// *** srik_host_model.sv ***
// host controller model: byte register accesses and the receive consume sequence
`timescale 1ns/10ps
module srik_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData,
  output logic receiveDoneCmd
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    receiveDoneCmd = 1'b0;
  end

  // released bus shows inverted last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask

  task automatic consume(input logic [15:0] n);
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] nxt;
    rd(8'h28, hi);
    rd(8'h29, lo);
    nxt = 16'({hi, lo} + n);
    wr(8'h28, nxt[15:8]);
    wr(8'h29, nxt[7:0]);
    @(negedge clk);
    receiveDoneCmd = 1'b1;
    @(negedge clk);
    receiveDoneCmd = 1'b0;
  endtask
endmodule

// *** srik_regs_test.sv ***
// self-checking bench for the socket rx / irq / keep-alive register group
`timescale 1ns/10ps
module srik_regs_test;
  import srik_pkg::*;
  localparam int UNIT = 4;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, receiveDoneCmd;
  logic sockInitCmd = 1'b0;
  logic manualKaCmd = 1'b0;
  logic rxWrAdvance = 1'b0;
  logic [15:0] rxByteCount = 16'h0000;
  logic [4:0] sockEvent = 5'h00;
  logic [4:0] eventFlagClear = 5'h00;
  logic globalSockBit = 1'b0;
  logic [7:0] socketState = 8'h00;
  logic tcpMode = 1'b0;
  logic dataXfer = 1'b0;
  logic [15:0] rxReadPtr, rxFreedPtr, rxWritePtr, ipFragField;
  logic [7:0] keepaliveInterval;
  logic probePacket, hostIrqPinLow;
  logic [4:0] socketEventFlags;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int probes = 0;

  srik_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .receiveDoneCmd(receiveDoneCmd));

  srik_regs #(.KA_UNIT_CYCLES(UNIT), .STATE_CONNECTED(8'h01)) uut (.clk(clk),
    .sys_rst(sysRst), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .sockInitCmd(sockInitCmd), .receiveDoneCmd(receiveDoneCmd),
    .manualKaCmd(manualKaCmd), .rxWrAdvance(rxWrAdvance), .rxByteCount(rxByteCount),
    .sockEvent(sockEvent), .eventFlagClear(eventFlagClear),
    .globalSockBit(globalSockBit), .socketState(socketState), .tcpMode(tcpMode),
    .dataXfer(dataXfer), .rxReadPtr(rxReadPtr), .rxFreedPtr(rxFreedPtr),
    .rxWritePtr(rxWritePtr), .ipFragField(ipFragField),
    .keepaliveInterval(keepaliveInterval), .probePacket(probePacket),
    .socketEventFlags(socketEventFlags), .hostIrqPinLow(hostIrqPinLow));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (probePacket === 1'b1) begin
      probes <= probes + 1;
    end
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------------------
  // expectations and helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] wrapAdd(input logic [15:0] a, input logic [15:0] b);
    return 16'(a + b);
  endfunction

  function automatic logic [7:0] rstVal(input int i);
    return (i == 4) ? SRIK_RST_MASK : ((i == 5) ? SRIK_RST_FRAG[15:8] : 8'h00);
  endfunction

  function automatic logic irqHigh(input logic [7:0] m, input logic g);
    return !((m[4:0] != 5'h00) && g);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin : main
    logic [15:0] expWr, cnt, v;
    logic [7:0] m, d;
    int gap;
    void'($urandom(32'h2380aa80));
    repeat (6) @(negedge clk);
    sysRst = 1'b0;
    chk({15'h0, hostIrqPinLow}, 16'h0001, "irq idle");
    for (int i = 0; i < 9; i++) begin
      host.rd(8'h28 + 8'(i), d);
      chk({8'h00, d}, {8'h00, rstVal(i)}, "reset read");
    end
    host.wr(SRIK_OFS_RXRD_HI, 8'h12);
    host.wr(SRIK_OFS_RXRD_LO, 8'h34);
    chk(rxReadPtr, 16'h1234, "read ptr write");
    host.rd(SRIK_OFS_RXRD_LO, d);
    chk({8'h00, d}, 16'h0034, "read ptr lsb");
    host.wr(SRIK_OFS_RXWR_HI, 8'hff);
    chk(rxWritePtr, 16'h0000, "write ptr read-only");
    expWr = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      cnt = (i == 3) ? 16'hffff : 16'($urandom_range(1, 65535));
      @(negedge clk);
      rxByteCount = cnt;
      rxWrAdvance = 1'b1;
      @(negedge clk);
      rxWrAdvance = 1'b0;
      expWr = wrapAdd(expWr, cnt);
      chk(rxWritePtr, expWr, "write ptr advance");
    end
    ce = 1'b0;
    pulse(rxWrAdvance);
    ce = 1'b1;
    chk(rxWritePtr, expWr, "frozen while ce low");
    host.rd(SRIK_OFS_RXWR_HI, d);
    chk({8'h00, d}, {8'h00, expWr[15:8]}, "write ptr msb");
    host.wr(SRIK_OFS_RXRD_HI, 8'hff);
    host.wr(SRIK_OFS_RXRD_LO, 8'hf0);
    host.consume(16'h0020);
    chk(rxReadPtr, wrapAdd(16'hfff0, 16'h0020), "read ptr wrap");
    chk(rxFreedPtr, 16'h0010, "freed position");
    pulse(sockInitCmd);
    chk(rxReadPtr, 16'h0000, "init read ptr");
    chk(rxWritePtr, 16'h0000, "init write ptr");
    for (int i = 0; i < 8; i++) begin
      m = (i < 5) ? (8'h01 << i) : (8'($urandom) | 8'h01);
      if (i == 5) begin
        m = 8'he0;
      end
      globalSockBit = (i != 6);
      host.wr(SRIK_OFS_MASK, m);
      host.rd(SRIK_OFS_MASK, d);
      chk({8'h00, d}, {8'h00, m}, "mask readback");
      @(negedge clk);
      sockEvent = 5'h1f;
      @(negedge clk);
      sockEvent = 5'h00;
      @(negedge clk);
      chk({11'h0, socketEventFlags}, {11'h0, m[4:0]}, "flags");
      chk({15'h0, hostIrqPinLow}, {15'h0, irqHigh(m, globalSockBit)}, "irq");
      eventFlagClear = 5'h1f;
      @(negedge clk);
      eventFlagClear = 5'h00;
    end
    @(negedge clk);
    sockEvent = 5'h01;
    eventFlagClear = 5'h1f;
    @(negedge clk);
    sockEvent = 5'h00;
    chk({11'h0, socketEventFlags}, 16'h0001, "set beats clear");
    @(negedge clk);
    eventFlagClear = 5'h00;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'($urandom) : 16'h0000;
      host.wr(SRIK_OFS_FRAG_HI, v[15:8]);
      host.wr(SRIK_OFS_FRAG_LO, v[7:0]);
      chk(ipFragField, v, "fragment field");
    end
    tcpMode = 1'b1;
    socketState = 8'h01;
    cyc(2);
    v = 16'(probes);
    pulse(manualKaCmd);
    cyc(2);
    chk(16'(probes) - v, 16'h0000, "probe before data");
    pulse(dataXfer);
    cyc(1);
    v = 16'(probes);
    pulse(manualKaCmd);
    cyc(2);
    chk(16'(probes) - v, 16'h0001, "manual probe");
    host.wr(SRIK_OFS_KAIVL, 8'h03);
    chk({8'h00, keepaliveInterval}, 16'h0003, "interval");
    v = 16'(probes);
    pulse(manualKaCmd);
    cyc(1);
    chk(16'(probes) - v, 16'h0000, "manual ignored");
    gap = 0;
    while (probePacket !== 1'b1 && gap < 40) begin
      @(negedge clk);
      gap++;
    end
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (probePacket !== 1'b1 && gap < 40);
    chk(16'(gap), 16'(3 * UNIT), "probe period");
    host.wr(SRIK_OFS_KAIVL, 8'h00);
    v = 16'(probes);
    cyc(40);
    chk(16'(probes) - v, 16'h0000, "auto off");
    host.wr(SRIK_OFS_KAIVL, 8'h02);
    tcpMode = 1'b0;
    cyc(2);
    v = 16'(probes);
    pulse(dataXfer);
    cyc(40);
    chk(16'(probes) - v, 16'h0000, "non-tcp");
    report_and_stop();
  end
endmodule
